// ---- hdl/cell_fault_status_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fault_bank_defs.svh"

module cell_fault_status_bank
  import fault_bank_pkg::*;
#(
  parameter int READING_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [`APB_DATA_W-1:0] pwdata,
  output logic [`APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] cell_undervolt_flag,
  input wire logic [7:0] input_overtemp_flag,
  input wire logic [7:0] input_undertemp_flag,
  input wire logic aux_compare_valid,
  input wire logic [7:0][READING_W-1:0] aux_main_reading,
  input wire logic [7:0][READING_W-1:0] aux_redundant_reading,
  input wire logic cell_compare_valid,
  input wire logic openwire_valid,
  input wire logic [15:0][READING_W-1:0] main_cell_reading,
  input wire logic [15:0][READING_W-1:0] redundant_cell_reading,
  input wire logic balance_openwire_valid,
  input wire logic [15:0] balance_openwire_fail,
  output logic irq
);

  // ==========================================
  // Storage
  status_byte_t cell_low_undervolt_flags;
  status_byte_t aux_overtemp_flags;
  status_byte_t aux_undertemp_flags;
  status_byte_t aux_pin_compare_results;
  status_byte_t cell_high_compare_results;
  status_byte_t cell_low_compare_results;
  status_byte_t cell_high_openwire_results;
  status_byte_t cell_low_openwire_results;
  status_byte_t balance_high_openwire_results;
  status_byte_t balance_low_openwire_results;
  logic [`AUX_THR_W-1:0] aux_compare_threshold;
  logic [`CELL_THR_W-1:0] cell_compare_threshold;
  logic [`OPENWIRE_THR_W-1:0] openwire_threshold;
  logic [`EVENT_W-1:0] event_status;
  logic [`EVENT_W-1:0] event_enable;

  logic [7:0] aux_pin_compare_fail;
  logic [15:0] cell_compare_fail;
  logic [15:0] cell_openwire_fail;
  logic [7:0] next_aux_pin_compare;
  logic [15:0] next_cell_compare;
  logic [15:0] next_cell_openwire;
  logic [15:0] next_balance_openwire;
  logic [`EVENT_W-1:0] event_raise;
  logic [`EVENT_W-1:0] event_clear;
  logic [`EVENT_W-1:0] next_event_status;
  logic [`EVENT_W-1:0] next_event_enable;

  // ==========================================
  // Decoding helpers
  function automatic logic diff_exceeds(
    input logic [READING_W-1:0] a,
    input logic [READING_W-1:0] b,
    input logic [READING_W-1:0] thr
  );
    logic [READING_W-1:0] d;
    d = (a > b) ? (a - b) : (b - a);
    return d > thr;
  endfunction

  function automatic logic is_mapped(input logic [`REG_IDX_W-1:0] idx);
    case (idx)
      `IDX_CELL_LOW_UNDERVOLT, `IDX_AUX_OVERTEMP, `IDX_AUX_UNDERTEMP,
      `IDX_AUX_PIN_COMPARE, `IDX_CELL_HIGH_COMPARE, `IDX_CELL_LOW_COMPARE,
      `IDX_CELL_HIGH_OPENWIRE, `IDX_CELL_LOW_OPENWIRE,
      `IDX_BALANCE_HIGH_OPENWIRE, `IDX_BALANCE_LOW_OPENWIRE,
      `IDX_AUX_COMPARE_THRESHOLD, `IDX_CELL_COMPARE_THRESHOLD,
      `IDX_OPENWIRE_THRESHOLD, `IDX_EVENT_STATUS, `IDX_EVENT_CLEAR,
      `IDX_EVENT_ENABLE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic is_writable(input logic [`REG_IDX_W-1:0] idx);
    case (idx)
      `IDX_AUX_COMPARE_THRESHOLD, `IDX_CELL_COMPARE_THRESHOLD,
      `IDX_OPENWIRE_THRESHOLD, `IDX_EVENT_CLEAR,
      `IDX_EVENT_ENABLE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================
  // Per-channel comparisons
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_aux
      assign aux_pin_compare_fail[gi] = diff_exceeds(aux_main_reading[gi],
        aux_redundant_reading[gi], READING_W'(aux_compare_threshold));
    end
    for (gi = 0; gi < 16; gi++) begin : g_cell
      assign cell_compare_fail[gi] = diff_exceeds(main_cell_reading[gi],
        redundant_cell_reading[gi], READING_W'(cell_compare_threshold));
      // Threshold sits in the low bits of the reading scale
      assign cell_openwire_fail[gi] =
        main_cell_reading[gi] < READING_W'(openwire_threshold);
    end
  endgenerate

  // Results hold between diagnostic runs; a pass clears the bit
  assign next_aux_pin_compare = aux_compare_valid ?
    aux_pin_compare_fail : aux_pin_compare_results;
  assign next_cell_compare = cell_compare_valid ? cell_compare_fail :
    {cell_high_compare_results, cell_low_compare_results};
  assign next_cell_openwire = openwire_valid ? cell_openwire_fail :
    {cell_high_openwire_results, cell_low_openwire_results};
  assign next_balance_openwire = balance_openwire_valid ? balance_openwire_fail :
    {balance_high_openwire_results, balance_low_openwire_results};

  // ==========================================
  // Status bytes, never touched by the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_low_undervolt_flags <= `STATUS_RST;
      aux_overtemp_flags <= `STATUS_RST;
      aux_undertemp_flags <= `STATUS_RST;
    end else begin
      cell_low_undervolt_flags <= cell_undervolt_flag;
      aux_overtemp_flags <= input_overtemp_flag;
      aux_undertemp_flags <= input_undertemp_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_pin_compare_results <= `STATUS_RST;
      cell_high_compare_results <= `STATUS_RST;
      cell_low_compare_results <= `STATUS_RST;
    end else begin
      aux_pin_compare_results <= next_aux_pin_compare;
      cell_high_compare_results <= next_cell_compare[15:8];
      cell_low_compare_results <= next_cell_compare[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_high_openwire_results <= `STATUS_RST;
      cell_low_openwire_results <= `STATUS_RST;
      balance_high_openwire_results <= `STATUS_RST;
      balance_low_openwire_results <= `STATUS_RST;
    end else begin
      cell_high_openwire_results <= next_cell_openwire[15:8];
      cell_low_openwire_results <= next_cell_openwire[7:0];
      balance_high_openwire_results <= next_balance_openwire[15:8];
      balance_low_openwire_results <= next_balance_openwire[7:0];
    end
  end

  // ==========================================
  // APB slave
  logic setup_phase;
  logic write_done;
  logic [`REG_IDX_W-1:0] reg_idx;
  logic [`APB_DATA_W-1:0] read_value;

  assign setup_phase = psel && !penable;
  // Writes land only at the edge where the master sees pready
  assign write_done = psel && penable && pwrite && pready;
  assign reg_idx = paddr[`APB_ADDR_W-1:2];

  always_comb begin
    read_value = '0;
    case (reg_idx)
      `IDX_CELL_LOW_UNDERVOLT: read_value[7:0] = cell_low_undervolt_flags;
      `IDX_AUX_OVERTEMP: read_value[7:0] = aux_overtemp_flags;
      `IDX_AUX_UNDERTEMP: read_value[7:0] = aux_undertemp_flags;
      `IDX_AUX_PIN_COMPARE: read_value[7:0] = aux_pin_compare_results;
      `IDX_CELL_HIGH_COMPARE: read_value[7:0] = cell_high_compare_results;
      `IDX_CELL_LOW_COMPARE: read_value[7:0] = cell_low_compare_results;
      `IDX_CELL_HIGH_OPENWIRE: read_value[7:0] = cell_high_openwire_results;
      `IDX_CELL_LOW_OPENWIRE: read_value[7:0] = cell_low_openwire_results;
      `IDX_BALANCE_HIGH_OPENWIRE: read_value[7:0] = balance_high_openwire_results;
      `IDX_BALANCE_LOW_OPENWIRE: read_value[7:0] = balance_low_openwire_results;
      `IDX_AUX_COMPARE_THRESHOLD: read_value[`AUX_THR_W-1:0] = aux_compare_threshold;
      `IDX_CELL_COMPARE_THRESHOLD: read_value[`CELL_THR_W-1:0] = cell_compare_threshold;
      `IDX_OPENWIRE_THRESHOLD: read_value[`OPENWIRE_THR_W-1:0] = openwire_threshold;
      `IDX_EVENT_STATUS: read_value[`EVENT_W-1:0] = event_status;
      `IDX_EVENT_ENABLE: read_value[`EVENT_W-1:0] = event_enable;
      default: read_value = '0;
    endcase
  end

  // Answer is prepared in the setup cycle, so no wait states are inserted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      prdata <= (setup_phase && !pwrite) ? read_value : '0;
      // Refused transfers still complete, so a master never waits on an error
      pslverr <= setup_phase && (paddr[1:0] != 2'b00 || !is_mapped(reg_idx) ||
        (pwrite && !is_writable(reg_idx)));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_compare_threshold <= `AUX_THR_RST;
      cell_compare_threshold <= `CELL_THR_RST;
      openwire_threshold <= `OPENWIRE_THR_RST;
      event_enable <= `EVENT_RST;
    end else if (write_done && !pslverr) begin
      case (reg_idx)
        `IDX_AUX_COMPARE_THRESHOLD: aux_compare_threshold <= pwdata[`AUX_THR_W-1:0];
        `IDX_CELL_COMPARE_THRESHOLD: cell_compare_threshold <= pwdata[`CELL_THR_W-1:0];
        `IDX_OPENWIRE_THRESHOLD: openwire_threshold <= pwdata[`OPENWIRE_THR_W-1:0];
        `IDX_EVENT_ENABLE: event_enable <= pwdata[`EVENT_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Events and interrupt
  // A register raises its event when any of its bits goes from 0 to 1
  assign event_raise[EV_CELL_LOW_UNDERVOLT] = |(cell_undervolt_flag & ~cell_low_undervolt_flags);
  assign event_raise[EV_AUX_OVERTEMP] = |(input_overtemp_flag & ~aux_overtemp_flags);
  assign event_raise[EV_AUX_UNDERTEMP] = |(input_undertemp_flag & ~aux_undertemp_flags);
  assign event_raise[EV_AUX_PIN_COMPARE] = |(next_aux_pin_compare & ~aux_pin_compare_results);
  assign event_raise[EV_CELL_HIGH_COMPARE] =
    |(next_cell_compare[15:8] & ~cell_high_compare_results);
  assign event_raise[EV_CELL_LOW_COMPARE] =
    |(next_cell_compare[7:0] & ~cell_low_compare_results);
  assign event_raise[EV_CELL_HIGH_OPENWIRE] =
    |(next_cell_openwire[15:8] & ~cell_high_openwire_results);
  assign event_raise[EV_CELL_LOW_OPENWIRE] =
    |(next_cell_openwire[7:0] & ~cell_low_openwire_results);
  assign event_raise[EV_BALANCE_HIGH_OPENWIRE] =
    |(next_balance_openwire[15:8] & ~balance_high_openwire_results);
  assign event_raise[EV_BALANCE_LOW_OPENWIRE] =
    |(next_balance_openwire[7:0] & ~balance_low_openwire_results);

  assign event_clear = (write_done && !pslverr && reg_idx == `IDX_EVENT_CLEAR) ?
    pwdata[`EVENT_W-1:0] : `EVENT_RST;
  // A new event in the clearing cycle survives the clear
  assign next_event_status = (event_status & ~event_clear) | event_raise;
  // An enable written in this cycle already counts, so irq never lags its status bits
  assign next_event_enable = (write_done && !pslverr && reg_idx == `IDX_EVENT_ENABLE) ?
    pwdata[`EVENT_W-1:0] : event_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status <= `EVENT_RST;
      irq <= 1'b0;
    end else begin
      event_status <= next_event_status;
      irq <= |(next_event_status & next_event_enable);
    end
  end

  // ==========================================
  // Checks
  // At the edge that releases reset the flops are still cleared, so the
  // source-following checks start only once presetn is sampled high
  AST_UV_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> cell_low_undervolt_flags == $past(cell_undervolt_flag))
    else $error("undervolt byte does not follow comparator");
  AST_OT_BIT0: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_overtemp_flag[0] ##1 input_overtemp_flag[0] |-> aux_overtemp_flags[0])
    else $error("overtemp input 1 not at bit 0");
  AST_UT_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && $stable(input_undertemp_flag)
      |=> aux_undertemp_flags == $past(input_undertemp_flag, 2))
    else $error("undertemp byte mismatch");
  AST_AUX_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
    aux_compare_valid && diff_exceeds(aux_main_reading[0], aux_redundant_reading[0],
      READING_W'(aux_compare_threshold)) |=> aux_pin_compare_results[0])
    else $error("aux pin compare fail not set");
  AST_AUX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !aux_compare_valid |=> $stable(aux_pin_compare_results))
    else $error("aux compare results changed without a run");
  AST_CELL_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    cell_compare_valid && diff_exceeds(main_cell_reading[10], redundant_cell_reading[10],
      READING_W'(cell_compare_threshold)) |=> cell_high_compare_results[2])
    else $error("cell 11 compare fail not at bit 2");
  AST_CELL_LOW_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    cell_compare_valid && !diff_exceeds(main_cell_reading[0], redundant_cell_reading[0],
      READING_W'(cell_compare_threshold)) |=> !cell_low_compare_results[0])
    else $error("cell 1 compare pass not cleared");
  AST_OW_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    openwire_valid && main_cell_reading[15] >= READING_W'(openwire_threshold)
      |=> !cell_high_openwire_results[7])
    else $error("cell 16 open wire set without cause");
  AST_OW_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    openwire_valid && main_cell_reading[0] < READING_W'(openwire_threshold)
      |=> cell_low_openwire_results[0])
    else $error("cell 1 open wire not set");
  AST_BAL: assert property (@(posedge pclk) disable iff (!presetn)
    balance_openwire_valid |=> {balance_high_openwire_results,
      balance_low_openwire_results} == $past(balance_openwire_fail))
    else $error("balance open wire bytes mismatch");
  AST_RO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && pwrite && reg_idx == `IDX_CELL_LOW_COMPARE
      |=> pready && pslverr ##1 $stable(cell_low_compare_results) || cell_compare_valid)
    else $error("write to status byte not refused");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    |(event_status & event_enable) |-> irq)
    else $error("interrupt low with enabled event");
  AST_IRQ_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> |(event_status & event_enable))
    else $error("interrupt high with no enabled event");
  // A raise that meets a clear in the same cycle must still leave its bit set
  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && |event_raise |=> (event_status & $past(event_raise)) == $past(event_raise))
    else $error("raised event bit lost");

  // ==========================================
  // Result bytes move only on their strobes
  AST_AUX_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    aux_compare_valid && !diff_exceeds(aux_main_reading[7], aux_redundant_reading[7],
      READING_W'(aux_compare_threshold)) |=> !aux_pin_compare_results[7])
    else $error("aux pin 8 compare pass not cleared");
  AST_CELL_LOW_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
    cell_compare_valid && diff_exceeds(main_cell_reading[3], redundant_cell_reading[3],
      READING_W'(cell_compare_threshold)) |=> cell_low_compare_results[3])
    else $error("cell 4 compare fail not at bit 3");
  AST_CELL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !cell_compare_valid |=> $stable({cell_high_compare_results, cell_low_compare_results}))
    else $error("cell compare results changed without a run");
  AST_OW_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !openwire_valid |=> $stable({cell_high_openwire_results, cell_low_openwire_results}))
    else $error("open wire results changed without a run");
  AST_BAL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !balance_openwire_valid
      |=> $stable({balance_high_openwire_results, balance_low_openwire_results}))
    else $error("balance results changed without a run");

  // ==========================================
  // Bus timing
  // One access cycle per setup; answer fields stay idle outside it, so a
  // master that samples late sees zeros rather than stale data
  AST_PREADY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready)
    else $error("no ready after setup");
  AST_PREADY_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held beyond one cycle");
  AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  AST_PRDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == '0)
    else $error("read data not cleared outside access");

endmodule

`default_nettype wire

// ---- hdl/fault_bank_defs.svh ----
`ifndef FAULT_BANK_DEFS_SVH
`define FAULT_BANK_DEFS_SVH

// ==========================================
// Bus geometry
`define APB_ADDR_W 13
`define APB_DATA_W 32
`define REG_IDX_W 11

// ==========================================
// Register indices, byte address is four times the index
`define IDX_CELL_LOW_UNDERVOLT 11'h53f
`define IDX_AUX_OVERTEMP 11'h540
`define IDX_AUX_UNDERTEMP 11'h541
`define IDX_AUX_PIN_COMPARE 11'h543
`define IDX_CELL_HIGH_COMPARE 11'h545
`define IDX_CELL_LOW_COMPARE 11'h546
`define IDX_CELL_HIGH_OPENWIRE 11'h548
`define IDX_CELL_LOW_OPENWIRE 11'h549
`define IDX_BALANCE_HIGH_OPENWIRE 11'h54b
`define IDX_BALANCE_LOW_OPENWIRE 11'h54c
`define IDX_AUX_COMPARE_THRESHOLD 11'h560
`define IDX_CELL_COMPARE_THRESHOLD 11'h561
`define IDX_OPENWIRE_THRESHOLD 11'h562
`define IDX_EVENT_STATUS 11'h563
`define IDX_EVENT_CLEAR 11'h564
`define IDX_EVENT_ENABLE 11'h565

// ==========================================
// Field widths and reset values
`define STATUS_W 8
`define STATUS_RST 8'h00
`define AUX_THR_W 3
`define AUX_THR_RST 3'h0
`define CELL_THR_W 5
`define CELL_THR_RST 5'h00
`define OPENWIRE_THR_W 4
`define OPENWIRE_THR_RST 4'h0
`define EVENT_W 10
`define EVENT_RST 10'h000

`endif

// ---- hdl/fault_bank_pkg.sv ----
package fault_bank_pkg;
  // Bit positions of the event status, enable and clear registers
  typedef enum logic [3:0] {
    EV_CELL_LOW_UNDERVOLT,
    EV_AUX_OVERTEMP,
    EV_AUX_UNDERTEMP,
    EV_AUX_PIN_COMPARE,
    EV_CELL_HIGH_COMPARE,
    EV_CELL_LOW_COMPARE,
    EV_CELL_HIGH_OPENWIRE,
    EV_CELL_LOW_OPENWIRE,
    EV_BALANCE_HIGH_OPENWIRE,
    EV_BALANCE_LOW_OPENWIRE
  } event_bit_e;
  typedef logic [7:0] status_byte_t;
endpackage

// ---- test/tb_cell_fault_status_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fault_bank_defs.svh"

module tb_cell_fault_status_bank;
  typedef struct packed {
    logic [10:0] idx;
    logic [7:0] pat;
  } row_s;
  // Patterns are not bit-palindromes, so a reversed bit order shows up
  localparam row_s ROWS [10] = '{
    '{`IDX_CELL_LOW_UNDERVOLT, 8'h1e}, '{`IDX_AUX_OVERTEMP, 8'h07},
    '{`IDX_AUX_UNDERTEMP, 8'he0}, '{`IDX_AUX_PIN_COMPARE, 8'h35},
    '{`IDX_CELL_HIGH_COMPARE, 8'h6c}, '{`IDX_CELL_LOW_COMPARE, 8'h0b},
    '{`IDX_CELL_HIGH_OPENWIRE, 8'hd0}, '{`IDX_CELL_LOW_OPENWIRE, 8'h29},
    '{`IDX_BALANCE_HIGH_OPENWIRE, 8'h94}, '{`IDX_BALANCE_LOW_OPENWIRE, 8'h4e}};
  localparam logic [2:0] THR_A = 3'h5;
  localparam logic [4:0] THR_C = 5'h11;
  localparam logic [3:0] THR_O = 4'h9;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] cell_undervolt_flag, input_overtemp_flag, input_undertemp_flag;
  logic aux_compare_valid, cell_compare_valid, openwire_valid, balance_openwire_valid;
  logic [7:0][15:0] aux_main_reading, aux_redundant_reading;
  logic [15:0][15:0] main_cell_reading, redundant_cell_reading;
  logic [15:0] balance_openwire_fail;
  int fail_count, checks_done, k;

  cell_fault_status_bank #(.READING_W(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cell_undervolt_flag, .input_overtemp_flag,
    .input_undertemp_flag, .aux_compare_valid, .aux_main_reading, .aux_redundant_reading,
    .cell_compare_valid, .openwire_valid, .main_cell_reading, .redundant_cell_reading,
    .balance_openwire_valid, .balance_openwire_fail, .irq);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ==========================================
  // Reporting
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  task check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  // ==========================================
  // APB master: request held until pready is sampled high
  task apb(input logic w, input logic [12:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready === 1'b1) begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end else begin
      fail_count++;
      $display("unexpected at %0t: no answer on the bus", $time);
      tally_and_finish;
    end
  endtask

  task read_chk(input logic [10:0] idx, input logic [31:0] exp);
    apb(1'b0, {idx, 2'b00}, 32'h0);
    check_word(rd, exp);
    check_bit(er, 1'b0);
  endtask

  // ==========================================
  // Source stimulus: readings placed on each threshold or one step past it
  task drive(input logic [10:0] idx, input logic [7:0] p);
    int i;
    logic lo, b;
    lo = (idx == `IDX_CELL_LOW_COMPARE) || (idx == `IDX_CELL_LOW_OPENWIRE);
    @(posedge pclk);
    case (idx)
      `IDX_CELL_LOW_UNDERVOLT: cell_undervolt_flag <= p;
      `IDX_AUX_OVERTEMP: input_overtemp_flag <= p;
      `IDX_AUX_UNDERTEMP: input_undertemp_flag <= p;
      `IDX_AUX_PIN_COMPARE: begin
        for (i = 0; i < 8; i++) begin
          aux_main_reading[i] <= 16'h0100;
          aux_redundant_reading[i] <= 16'h0100 - THR_A - p[i];
        end
        aux_compare_valid <= 1'b1;
      end
      `IDX_CELL_HIGH_COMPARE, `IDX_CELL_LOW_COMPARE: begin
        for (i = 0; i < 16; i++) begin
          b = ((i < 8) == lo) ? p[i % 8] : 1'b0;
          main_cell_reading[i] <= 16'h0400;
          // Low half above, high half below: the difference is absolute
          redundant_cell_reading[i] <= (i < 8) ? 16'h0400 + THR_C + b : 16'h0400 - THR_C - b;
        end
        cell_compare_valid <= 1'b1;
      end
      `IDX_CELL_HIGH_OPENWIRE, `IDX_CELL_LOW_OPENWIRE: begin
        for (i = 0; i < 16; i++) begin
          b = ((i < 8) == lo) ? p[i % 8] : 1'b0;
          main_cell_reading[i] <= 16'(THR_O) - b;
        end
        openwire_valid <= 1'b1;
      end
      default: begin
        balance_openwire_fail <= (idx == `IDX_BALANCE_LOW_OPENWIRE) ? {8'h00, p} : {p, 8'h00};
        balance_openwire_valid <= 1'b1;
      end
    endcase
    @(posedge pclk);
    aux_compare_valid <= 1'b0;
    cell_compare_valid <= 1'b0;
    openwire_valid <= 1'b0;
    balance_openwire_valid <= 1'b0;
    @(posedge pclk);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cell_undervolt_flag, input_overtemp_flag, input_undertemp_flag} = '0;
    {aux_compare_valid, cell_compare_valid, openwire_valid, balance_openwire_valid} = '0;
    {aux_main_reading, aux_redundant_reading, main_cell_reading} = '0;
    redundant_cell_reading = '0;
    balance_openwire_fail = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 10; k++) begin
      read_chk(ROWS[k].idx, 32'h0);
    end
    apb(1'b1, {`IDX_AUX_COMPARE_THRESHOLD, 2'b00}, {29'h0, THR_A});
    apb(1'b1, {`IDX_CELL_COMPARE_THRESHOLD, 2'b00}, {27'h0, THR_C});
    apb(1'b1, {`IDX_OPENWIRE_THRESHOLD, 2'b00}, {28'h0, THR_O});
    $display("test reset values done");
    for (k = 0; k < 10; k++) begin
      drive(ROWS[k].idx, ROWS[k].pat);
      read_chk(ROWS[k].idx, {24'h0, ROWS[k].pat});
      check_bit(irq, 1'b0);
    end
    $display("test row table done");
    // Writes to status and reads of bad addresses are refused; the writes change nothing
    apb(1'b1, {`IDX_AUX_OVERTEMP, 2'b00}, 32'hff);
    check_bit(er, 1'b1);
    read_chk(`IDX_AUX_OVERTEMP, {24'h0, ROWS[1].pat});
    apb(1'b1, {`IDX_CELL_LOW_COMPARE, 2'b00}, 32'hff);
    check_bit(er, 1'b1);
    read_chk(`IDX_CELL_LOW_COMPARE, {24'h0, ROWS[5].pat});
    apb(1'b0, 13'h1ffc, 32'h0);
    check_bit(er, 1'b1);
    apb(1'b0, {`IDX_AUX_OVERTEMP, 2'b01}, 32'h0);
    check_bit(er, 1'b1);
    // Readings move without a strobe: stored results hold
    @(posedge pclk);
    aux_redundant_reading <= '0;
    read_chk(`IDX_AUX_PIN_COMPARE, {24'h0, ROWS[3].pat});
    drive(`IDX_CELL_LOW_UNDERVOLT, 8'h00);
    read_chk(`IDX_CELL_LOW_UNDERVOLT, 32'h0);
    $display("test refusals done");
    // Every status register rose once, so every event bit is pending
    read_chk(`IDX_EVENT_STATUS, 32'h3ff);
    apb(1'b1, {`IDX_EVENT_ENABLE, 2'b00}, 32'h001);
    repeat (2) @(posedge pclk);
    check_bit(irq, 1'b1);
    apb(1'b1, {`IDX_EVENT_CLEAR, 2'b00}, 32'h3ff);
    repeat (2) @(posedge pclk);
    check_bit(irq, 1'b0);
    read_chk(`IDX_EVENT_STATUS, 32'h0);
    drive(`IDX_CELL_LOW_UNDERVOLT, 8'h40);
    check_bit(irq, 1'b1);
    read_chk(`IDX_EVENT_STATUS, 32'h001);
    apb(1'b1, {`IDX_EVENT_ENABLE, 2'b00}, 32'h0);
    repeat (2) @(posedge pclk);
    check_bit(irq, 1'b0);
    $display("test interrupt done");
    // Second reset in mid-run clears latched results
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    read_chk(`IDX_CELL_HIGH_COMPARE, 32'h0);
    read_chk(`IDX_BALANCE_LOW_OPENWIRE, 32'h0);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
